// [dbc_pkg.sv]
// dbc_pkg: constants for the dual bridge chopper control block
// assumes a 40 MHz system clock and a classic Wishbone register port
package dbc_pkg;

  // register byte addresses, one aligned 32-bit word each
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // control byte field positions
  localparam int A_CUR_HI = 5;
  localparam int A_CUR_LO = 4;
  localparam int A_PHASE = 3;
  localparam int B_CUR_HI = 2;
  localparam int B_CUR_LO = 1;
  localparam int B_PHASE = 0;
  localparam int CTRL_W = 6;

  // status field positions
  localparam int ST_OVL_N = 6;
  localparam int ST_SPARE = 7;

  // both bridges at zero current after reset
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h36;

  // current field codes
  localparam logic [1:0] CUR_ZERO = 2'h3;
  localparam logic [1:0] CUR_LOW = 2'h2;
  localparam logic [1:0] CUR_MID = 2'h1;
  localparam logic [1:0] CUR_FULL = 2'h0;

  // timing: blanking window after each sink turn-on
  localparam int MCLK_PERIOD_NS = 25;
  localparam int BLANK_TIME_NS = 1000;
  localparam int BLANK_W = 6;
  localparam logic [BLANK_W-1:0] BLANK_CYC =
    BLANK_W'((BLANK_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [BLANK_W-1:0] BLANK_ONE = 6'h01;
  localparam logic [BLANK_W-1:0] BLANK_NONE = 6'h00;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// [dbc_chopper.sv]
// dbc_chopper: two bridge chopper control with a Wishbone register port
// assumes oscillator, comparator and overload pins are asynchronous to mclk
//
// Behaviour
// RULE_01 - bridge A polarity bit high drives A output one high, low reverses
// RULE_02 - bridge B polarity bit high drives B output one high, low reverses
// RULE_03 - bridge A current from bits five and four, bridge B from two and one
// RULE_04 - codes: 11 zero, 10 about 60 mA, 01 about 550 mA, 00 full scale
// RULE_05 - code 10 uses internal reference; other nonzero codes use sense resistor
// RULE_06 - code 11 holds all four drivers off regardless of comparator
// RULE_07 - leaving code 11 turns on the diagonal chosen by phase bit
// RULE_08 - comparator trip turns off the active sink transistor
// RULE_09 - next oscillator trigger turns sink on again
// RULE_10 - comparator ignored for a blanking window after each sink turn-on
// RULE_11 - on-time duty above 85 percent at 25 kHz; bridges may overlap
// RULE_12 - phase change turns off both transistors of old diagonal
// RULE_13 - bridge A starts at oscillator maximum, bridge B at minimum
// RULE_14 - stopped oscillator never turns a tripped bridge back on
// RULE_15 - an external chopping clock may replace the oscillator
// RULE_16 - source overload turns bridge off and sets overload flag
// RULE_17 - after overload the bridge stays off until a new control write
// RULE_18 - overload flag clears at the end of a control write
// RULE_19 - both bridges share one flag with no bridge indication
// RULE_20 - host isolates a fault by turning one bridge off
// RULE_21 - overload reported as status bit six low
// RULE_22 - control byte applied at end of write and held until next
// RULE_23 - threshold follows latched current field after each blanking window
`timescale 1ns/1ps
`default_nettype none

module dbc_bridge
  import dbc_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic phase, // latched polarity bit
  input wire logic [1:0] curField, // latched current field
  input wire logic trig, // one-cycle oscillator trigger for this bridge
  input wire logic cmp, // synchronised current comparator
  input wire logic ovlIn, // synchronised source overload
  input wire logic newWrite, // one-cycle end of control write
  output logic outOne, // high-side drive of output one
  output logic outTwo, // high-side drive of output two
  output logic sinkSwitchLeft, // sink drive under output one
  output logic sinkSwitchRight, // sink drive under output two
  output logic spikeBlank, // comparator blanking active
  output logic [1:0] threshSel, // threshold code in use
  output logic refInternal, // internal reference selected
  output logic ovlLatched // overload shutdown held
);

  typedef struct packed {
    logic sinkOn;
    logic decay;
    logic ovl;
    logic prevPhase;
    logic prevAct;
    logic [BLANK_W-1:0] blankCnt;
    logic [1:0] thresh;
  } dbc_bridge_t;

  dbc_bridge_t st;
  dbc_bridge_t next_st;
  logic zero;
  logic nextOvl;
  logic act;
  logic phaseChg;
  logic srcOn;

  // set beats the write-strobe clear, so a fresh overload is never lost
  assign zero = (curField == CUR_ZERO); // RULE_04
  assign nextOvl = ovlIn | (st.ovl & ~newWrite); // RULE_16 RULE_17
  assign act = ~zero & ~nextOvl; // RULE_06
  assign phaseChg = (phase != st.prevPhase);

  // chopping sequence: turn-on, blanking, comparator trip, retrigger
  always_comb
  begin
    next_st = st;
    next_st.ovl = nextOvl;
    next_st.prevPhase = phase;
    next_st.prevAct = act;
    if (!act)
    begin
      next_st.sinkOn = 1'b0; // RULE_06 RULE_16
      next_st.decay = 1'b0;
      next_st.blankCnt = BLANK_NONE;
      if (zero)
      begin
        next_st.thresh = CUR_ZERO; // RULE_06
      end
    end
    else if (phaseChg && st.prevAct)
    begin
      // both transistors off so current decays fast through the diodes
      next_st.sinkOn = 1'b0; // RULE_12
      next_st.decay = 1'b1; // RULE_12
      next_st.blankCnt = BLANK_NONE;
    end
    else if ((trig && !st.sinkOn) || !st.prevAct) // RULE_11
    begin
      // no trigger, no turn-on once running: a stopped oscillator leaves it off
      // a trigger while the sink conducts is no turn-on; restarting the
      // blanking there would hide the comparator for good on a fast clock
      next_st.sinkOn = 1'b1; // RULE_07 RULE_09 RULE_14
      next_st.decay = 1'b0;
      next_st.blankCnt = BLANK_CYC; // RULE_10
    end
    else if (st.blankCnt != BLANK_NONE)
    begin
      next_st.blankCnt = st.blankCnt - BLANK_ONE; // RULE_10
      if (st.blankCnt == BLANK_ONE)
      begin
        next_st.thresh = curField; // RULE_23
      end
    end
    else if (cmp && st.sinkOn)
    begin
      next_st.sinkOn = 1'b0; // RULE_08
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '{sinkOn: 1'b0, decay: 1'b0, ovl: 1'b0, prevPhase: 1'b0,
              prevAct: 1'b0, blankCnt: BLANK_NONE, thresh: CUR_ZERO};
    end
    else
    begin
      st <= next_st;
    end
  end

  // drives decoded from registered state; phase high picks output one high
  assign srcOn = st.prevAct & ~st.decay;
  assign outOne = srcOn & st.prevPhase; // RULE_01 RULE_02
  assign outTwo = srcOn & ~st.prevPhase; // RULE_01 RULE_02
  assign sinkSwitchRight = st.sinkOn & st.prevPhase; // RULE_07
  assign sinkSwitchLeft = st.sinkOn & ~st.prevPhase; // RULE_07
  assign spikeBlank = (st.blankCnt != BLANK_NONE);
  assign threshSel = st.thresh;
  assign refInternal = (st.thresh == CUR_LOW); // RULE_05
  assign ovlLatched = st.ovl;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_zero_all_off: assert property (zero |=> !(outOne | outTwo | sinkSwitchLeft | sinkSwitchRight)) // RULE_06
    else $error("drivers on at zero current");
  a_blank_hold: assert property ((spikeBlank && act && !phaseChg) |=> st.sinkOn) // RULE_10
    else $error("sink dropped during blanking");
  a_trip_off: assert property ((st.sinkOn && !spikeBlank && cmp && !trig && act && !phaseChg) |=> !st.sinkOn) // RULE_08
    else $error("comparator trip ignored");
  a_trig_on: assert property ((trig && act && st.prevAct && !phaseChg && !st.sinkOn) |=> (st.sinkOn && st.blankCnt == BLANK_CYC)) // RULE_09
    else $error("trigger did not restart sink");
  a_no_trig_off: assert property ((!st.sinkOn && st.prevAct && !trig) |=> !st.sinkOn) // RULE_14
    else $error("sink turned on without trigger");
  a_ovl_off: assert property (ovlIn |=> (!outOne && !outTwo && ovlLatched) [*2]) // RULE_16
    else $error("overload did not shut bridge");
  a_ovl_hold: assert property ((st.ovl && !newWrite) |=> st.ovl) // RULE_17
    else $error("overload released without write");
  a_phase_decay: assert property ((phaseChg && st.prevAct && act) |=> !(outOne | outTwo | sinkSwitchLeft | sinkSwitchRight)) // RULE_12
    else $error("old diagonal not turned off");
  a_thresh_follow: assert property ((st.blankCnt == BLANK_ONE && act && !trig && !phaseChg) |=> threshSel == $past(curField)) // RULE_23
    else $error("threshold not updated");
  a_ref_select: assert property (refInternal == (threshSel == CUR_LOW)) // RULE_05
    else $error("reference selection wrong");

  // zero-code threshold, turn-on, retrigger, decay and diagonal corners of the chopping sequence
  a_zero_thresh: assert property (zero |=> threshSel == CUR_ZERO) // RULE_06
    else $error("threshold not zero at zero current");
  a_retrig_keep: assert property ((trig && spikeBlank && act && st.prevAct && !phaseChg) |=> st.blankCnt == $past(st.blankCnt) - BLANK_ONE) // RULE_11
    else $error("retrigger stretched blanking");
  a_blank_start: assert property ($rose(st.sinkOn) |-> st.blankCnt == BLANK_CYC) // RULE_10
    else $error("turn-on without blanking");
  a_decay_trig: assert property ((st.decay && trig && act && !phaseChg) |=> (st.sinkOn && !st.decay)) // RULE_12
    else $error("new diagonal not turned on");
  a_diag_excl: assert property ((outOne || sinkSwitchRight) |-> !(outTwo || sinkSwitchLeft)) // RULE_07
    else $error("both diagonals driven");

endmodule // dbc_bridge

module dbc_chopper
  import dbc_pkg::*;
(
  input wire logic mclk, // 40 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [3:0] wb_adr_i, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic oscIn, // chopping oscillator level, own or external
  input wire logic cmpA, // bridge A current comparator
  input wire logic cmpB, // bridge B current comparator
  input wire logic srcOvlA, // bridge A source overload detect
  input wire logic srcOvlB, // bridge B source overload detect
  output logic bridgeAOutOne, // bridge A high side, output one
  output logic bridgeAOutTwo, // bridge A high side, output two
  output logic bridgeASinkSwitchLeft, // bridge A sink, output one side
  output logic bridgeASinkSwitchRight, // bridge A sink, output two side
  output logic bridgeBOutOne, // bridge B high side, output one
  output logic bridgeBOutTwo, // bridge B high side, output two
  output logic bridgeBSinkSwitchLeft, // bridge B sink, output one side
  output logic bridgeBSinkSwitchRight, // bridge B sink, output two side
  output logic spikeBlankOne, // bridge A blanking
  output logic spikeBlankTwo, // bridge B blanking
  output logic [1:0] threshSelA, // bridge A threshold code
  output logic [1:0] threshSelB, // bridge B threshold code
  output logic refInternalA, // bridge A internal reference
  output logic refInternalB, // bridge B internal reference
  output logic overcurrentFlag // shared overload flag, high when set
);

  typedef struct packed {
    logic oscMeta;
    logic oscSync;
    logic oscPrev;
    logic [1:0] cmpMeta;
    logic [1:0] cmpSync;
    logic [1:0] ovlMeta;
    logic [1:0] ovlSync;
    logic [CTRL_W-1:0] ctrl;
    logic ack;
    logic [31:0] datOut;
  } dbc_top_t;

  dbc_top_t st;
  dbc_top_t next_st;
  logic req;
  logic wrCtrl;
  logic trigA;
  logic trigB;
  logic ovlA;
  logic ovlB;
  logic [31:0] statusWord;

  // the oscillator may be any push-pull clock; only its edges matter
  assign trigA = st.oscSync & ~st.oscPrev; // RULE_13 RULE_15
  assign trigB = ~st.oscSync & st.oscPrev; // RULE_13 RULE_15

  // a write is taken at the edge where ack is high, as the master samples it
  assign req = wb_cyc_i & wb_stb_i;
  assign wrCtrl = req & wb_we_i & st.ack & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0];

  // one flag for both bridges, reported active low
  assign overcurrentFlag = ovlA | ovlB; // RULE_19

  always_comb
  begin
    statusWord = WORD_ZERO;
    statusWord[ST_SPARE] = 1'b1;
    statusWord[ST_OVL_N] = ~overcurrentFlag; // RULE_21
  end

  // synchronisers, register file and bus answer
  always_comb
  begin
    next_st = st;
    next_st.oscMeta = oscIn;
    next_st.oscSync = st.oscMeta;
    next_st.oscPrev = st.oscSync;
    next_st.cmpMeta = {cmpB, cmpA};
    next_st.cmpSync = st.cmpMeta;
    next_st.ovlMeta = {srcOvlB, srcOvlA};
    next_st.ovlSync = st.ovlMeta;
    next_st.ack = req & ~st.ack;
    if (wrCtrl)
    begin
      next_st.ctrl = wb_dat_i[CTRL_W-1:0]; // RULE_22
    end
    if (req && !st.ack && !wb_we_i)
    begin
      // unmapped addresses read as zero but are still acknowledged
      unique case (wb_adr_i)
        ADDR_CTRL: next_st.datOut = {26'h000_0000, st.ctrl};
        ADDR_STATUS: next_st.datOut = statusWord;
        default: next_st.datOut = WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '{oscMeta: 1'b0, oscSync: 1'b0, oscPrev: 1'b0, cmpMeta: 2'h0,
              cmpSync: 2'h0, ovlMeta: 2'h0, ovlSync: 2'h0, ctrl: CTRL_RESET,
              ack: 1'b0, datOut: WORD_ZERO};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.datOut;

  // bridge A: phase bit three, current bits five and four
  dbc_bridge uBridgeA (
    .mclk(mclk),
    .rstn(rstn),
    .phase(st.ctrl[A_PHASE]), // RULE_01
    .curField({st.ctrl[A_CUR_HI], st.ctrl[A_CUR_LO]}), // RULE_03
    .trig(trigA),
    .cmp(st.cmpSync[0]),
    .ovlIn(st.ovlSync[0]),
    .newWrite(wrCtrl), // RULE_17 RULE_18
    .outOne(bridgeAOutOne),
    .outTwo(bridgeAOutTwo),
    .sinkSwitchLeft(bridgeASinkSwitchLeft),
    .sinkSwitchRight(bridgeASinkSwitchRight),
    .spikeBlank(spikeBlankOne),
    .threshSel(threshSelA),
    .refInternal(refInternalA),
    .ovlLatched(ovlA)
  );

  // bridge B: phase bit zero, current bits two and one
  dbc_bridge uBridgeB (
    .mclk(mclk),
    .rstn(rstn),
    .phase(st.ctrl[B_PHASE]), // RULE_02
    .curField({st.ctrl[B_CUR_HI], st.ctrl[B_CUR_LO]}), // RULE_03
    .trig(trigB),
    .cmp(st.cmpSync[1]),
    .ovlIn(st.ovlSync[1]),
    .newWrite(wrCtrl), // RULE_17 RULE_18
    .outOne(bridgeBOutOne),
    .outTwo(bridgeBOutTwo),
    .sinkSwitchLeft(bridgeBSinkSwitchLeft),
    .sinkSwitchRight(bridgeBSinkSwitchRight),
    .spikeBlank(spikeBlankTwo),
    .threshSel(threshSelB),
    .refInternal(refInternalB),
    .ovlLatched(ovlB)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_write_apply: assert property (wrCtrl |=> st.ctrl == $past(wb_dat_i[CTRL_W-1:0])) // RULE_22
    else $error("control byte not applied");
  a_ctrl_hold: assert property (!wrCtrl |=> $stable(st.ctrl)) // RULE_22
    else $error("control byte changed without write");
  a_flag_clear: assert property ((wrCtrl && !st.ovlSync[0] && !st.ovlSync[1]) |=> !overcurrentFlag) // RULE_18
    else $error("overload flag not cleared by write");
  a_flag_bit6: assert property ((req && !st.ack && !wb_we_i && wb_adr_i == ADDR_STATUS) |=> wb_dat_o[ST_OVL_N] == !$past(overcurrentFlag)) // RULE_21
    else $error("status bit six wrong");
  a_offset_trig: assert property (trigA |-> !trigB) // RULE_13
    else $error("bridges triggered together");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // bus answer timing, read-back and the shared flag
  a_ack_answer: assert property ((req && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered");
  a_read_ctrl: assert property ((req && !st.ack && !wb_we_i && wb_adr_i == ADDR_CTRL) |=> wb_dat_o[CTRL_W-1:0] == $past(st.ctrl)) // RULE_22
    else $error("control read-back wrong");
  a_flag_set: assert property ((st.ovlSync[0] || st.ovlSync[1]) |=> overcurrentFlag) // RULE_16 RULE_19
    else $error("overload flag not set");

endmodule // dbc_chopper

`default_nettype wire

// [dbc_load_model.sv]
// dbc_load_model: winding, comparator and chopping clock beside dbc_chopper
// assumes active-high sink drives and the 40 MHz mclk
`timescale 1ns/1ps
`default_nettype none
module dbc_load_model #(
  parameter int RISE = 60 // sink cycles until the current crosses the threshold
) (
  input wire logic mclk, // system clock
  input wire logic rstn, // reset, active low
  input wire logic oscRun, // chopping clock runs while high
  input wire logic sinkA, // bridge A sink conducting
  input wire logic sinkB, // bridge B sink conducting
  output logic oscIn, // external chopping clock
  output logic cmpA, // bridge A comparator
  output logic cmpB // bridge B comparator
);
  int curA;
  int curB;
  // 200 ns chopping clock off the mclk grid; it stands still when stopped
  initial
  begin
    oscIn = 1'b0;
    #37;
    forever
    begin
      #100;
      if (oscRun) oscIn = ~oscIn;
    end
  end
  // current ramps while the sink conducts and collapses once it opens
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      curA <= 0;
      curB <= 0;
    end
    else
    begin
      curA <= sinkA ? curA + 1 : 0;
      curB <= sinkB ? curB + 1 : 0;
    end
  end
  assign cmpA = curA >= RISE;
  assign cmpB = curB >= RISE;
endmodule // dbc_load_model
`default_nettype wire

// [dbc_chopper_tb.sv]
// dbc_chopper_tb: self-checking bench for the dual bridge chopper
// assumes dbc_load_model plays the windings and the chopping clock
`timescale 1ns/1ps
`default_nettype none
module dbc_chopper_tb
  import dbc_pkg::*;
;
  logic mclk, rstn, cyc, stb, wbWe, oscRun, ovlA, ovlB, ack, flag;
  logic [3:0] adr, sel, drvA, drvB;
  logic [31:0] dat, rdat;
  logic [1:0] thA, thB;
  logic aOne, aTwo, aL, aR, bOne, bTwo, bL, bR, blA, blB, riA, riB, oscIn, cmpA, cmpB;
  logic [31:0] expQ[$];
  int fail_count = 0;
  int tests_run = 0;
  assign drvA = {aOne, aTwo, aL, aR};
  assign drvB = {bOne, bTwo, bL, bR};
  dbc_chopper dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wbWe), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .oscIn(oscIn), .cmpA(cmpA), .cmpB(cmpB), .srcOvlA(ovlA),
    .srcOvlB(ovlB), .bridgeAOutOne(aOne), .bridgeAOutTwo(aTwo),
    .bridgeASinkSwitchLeft(aL), .bridgeASinkSwitchRight(aR), .bridgeBOutOne(bOne),
    .bridgeBOutTwo(bTwo), .bridgeBSinkSwitchLeft(bL), .bridgeBSinkSwitchRight(bR),
    .spikeBlankOne(blA), .spikeBlankTwo(blB), .threshSelA(thA), .threshSelB(thB),
    .refInternalA(riA), .refInternalB(riB), .overcurrentFlag(flag));
  dbc_load_model load (.mclk(mclk), .rstn(rstn), .oscRun(oscRun), .sinkA(aL | aR),
    .sinkB(bL | bR), .oscIn(oscIn), .cmpA(cmpA), .cmpB(cmpB));
  // 40 MHz system clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // one classic cycle; waits for ack with a bound, releases after the ack edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbWe <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      fail_count++;
      $display("unexpected ack: expected 1, seen %b", ack);
      give_verdict();
    end
    else
    begin
      // released only after the rising edge that sampled ack high
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    wb(1'b0, a, 32'h0000_0000, 4'hf);
  endtask
  // read data is taken at the ack edge and matched with the oldest note
  always @(posedge mclk)
  begin
    if (cyc && ack && !wbWe)
    begin
      if (expQ.size() == 0)
        chk("unplanned read", 32'h0000_0000, 32'h0000_0001);
      else
        chk("read data", expQ.pop_front(), rdat);
    end
  end
  initial
  begin
    logic [1:0] ph;
    logic [5:0] c;
    logic on;
    logic pa;
    logic pb;
    int n;
    int ra;
    int rb;
    int ov;
    {rstn, cyc, stb, wbWe, oscRun, ovlA, ovlB} = 7'h00;
    adr = 4'h0;
    sel = 4'h0;
    dat = 32'h0000_0000;
    void'($urandom(7138));
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    // reset state, register map, ignored writes
    idle(1);
    chk("drivers at reset", 32'h0000_0000, 32'({drvA, drvB}));
    rd(ADDR_CTRL, 32'(CTRL_RESET));
    rd(ADDR_STATUS, 32'h0000_00c0);
    rd(4'h8, WORD_ZERO);
    wb(1'b1, ADDR_STATUS, 32'h0000_0000, 4'hf);
    wb(1'b1, ADDR_CTRL, 32'h0000_0000, 4'he);
    rd(ADDR_CTRL, 32'(CTRL_RESET));
    rd(ADDR_STATUS, 32'h0000_00c0);
    $display("test done: reset and register map");
    // every current code with random phases, each written after the zero code
    for (int k = 0; k < 4; k++)
    begin
      ph = 2'($urandom);
      c = {2'(k), ph[1], 2'(k), ph[0]};
      on = 2'(k) != CUR_ZERO;
      wb(1'b1, ADDR_CTRL, 32'(CTRL_RESET), 4'h1);
      wb(1'b1, ADDR_CTRL, 32'(c), 4'h1);
      rd(ADDR_CTRL, 32'(c));
      idle(50);
      chk("threshold", 32'({2'(k), 2'(k)}), 32'({thA, thB}));
      chk("internal ref", 32'({2{2'(k) == CUR_LOW}}), 32'({riA, riB}));
      chk("high sides", 32'({on & ph[1], on & ~ph[1], on & ph[0], on & ~ph[0]}),
        32'({aOne, aTwo, bOne, bTwo}));
      if (!on) chk("sinks at zero", 32'h0000_0000, 32'({aL, aR, bL, bR}));
    end
    $display("test done: current codes");
    // blanking window after turn-on
    wb(1'b1, ADDR_CTRL, 32'h0000_0000, 4'h1);
    idle(2);
    chk("sink after turn-on", 32'h0000_0001, 32'(aL));
    chk("blanking B", 32'h0000_0001, 32'(blB));
    n = 0;
    while (blA === 1'b1 && n < 100)
    begin
      n++;
      @(negedge mclk);
    end
    chk("blanking length", 32'(BLANK_CYC), 32'(n));
    // free-running chop on both bridges
    oscRun <= 1'b1;
    {ra, rb, ov, pa, pb} = '0;
    repeat (800)
    begin
      @(negedge mclk);
      if (aL && !pa) ra++;
      if (bL && !pb) rb++;
      if (aL && bL) ov++;
      pa = aL;
      pb = bL;
    end
    chk("chops", 32'h0000_0003, 32'({ra >= 4, rb >= 4}));
    chk("overlap", 32'h0000_0001, 32'(ov > 0));
    // stopped clock leaves tripped sinks off
    oscRun <= 1'b0;
    idle(300);
    chk("sinks, clock stopped", 32'h0000_0000, 32'({aL, aR, bL, bR}));
    wb(1'b1, ADDR_CTRL, 32'h0000_0008, 4'h1);
    idle(5);
    chk("old diagonal", 32'h0000_0001, 32'({drvA, bTwo}));
    oscRun <= 1'b1;
    idle(20);
    chk("new diagonal", 32'h0000_0002, 32'({aOne, aTwo}));
    $display("test done: chopping and phase");
    // overload on each bridge in turn; host isolates it by turning the other off
    wb(1'b1, ADDR_CTRL, 32'h0000_0000, 4'h1);
    idle(20);
    for (int b = 0; b < 2; b++)
    begin
      @(posedge mclk);
      ovlA <= (b == 0);
      ovlB <= (b == 1);
      idle(6);
      @(posedge mclk);
      {ovlA, ovlB} <= 2'h0;
      idle(10);
      chk("flag set", 32'h0000_0001, 32'(flag));
      chk("faulty bridge", 32'h0000_0000, 32'(b ? drvB : drvA));
      chk("other bridge", 32'h0000_0001, 32'(b ? aTwo : bTwo));
      rd(ADDR_STATUS, 32'h0000_0080);
      idle(100);
      chk("held off", 32'h0000_0000, 32'(b ? drvB : drvA));
      wb(1'b1, ADDR_CTRL, b ? 32'h0000_0030 : 32'h0000_0006, 4'h1);
      idle(3);
      chk("flag cleared", 32'h0000_0000, 32'(flag));
      chk("re-enabled", 32'h0000_0001, 32'(b ? bTwo : aTwo));
      rd(ADDR_STATUS, 32'h0000_00c0);
      wb(1'b1, ADDR_CTRL, 32'h0000_0000, 4'h1);
      idle(20);
    end
    $display("test done: overload");
    chk("pending reads", 32'h0000_0000, 32'(expQ.size()));
    give_verdict();
  end
endmodule // dbc_chopper_tb
`default_nettype wire
